// *** core/cmm_pkg.sv ***
package cmm_pkg;
    localparam int CMM_AXI_AW = 12;
    localparam int CMM_SPACE_BIT = 11;
    localparam int CMM_STREAM_MSB = 10;
    localparam int CMM_STREAM_LSB = 7;
    localparam int CMM_CHAN_MSB = 6;
    localparam int CMM_CHAN_LSB = 0;
    localparam int CMM_WORD_W = 12;
    localparam int CMM_SEL_W = 3;
    // Register space byte offsets
    localparam logic [10:0] CMM_OFS_CTRL = 11'h000;
    localparam logic [10:0] CMM_OFS_RATE = 11'h004;
    localparam logic [10:0] CMM_OFS_STAT = 11'h008;
    localparam logic [31:0] CMM_RATE_RST = 32'h00000000;
    // Memory select codes in control bits 2..0
    localparam logic [2:0] CMM_SEL_CONN = 3'h0;
    localparam logic [2:0] CMM_SEL_DATA = 3'h1;
    // Per-stream rate codes
    localparam logic [1:0] CMM_RATE_2M = 2'h0;
    localparam logic [1:0] CMM_RATE_4M = 2'h1;
    localparam logic [1:0] CMM_RATE_8M = 2'h2;
    localparam logic [6:0] CMM_LAST_2M = 7'h1f;
    localparam logic [6:0] CMM_LAST_4M = 7'h3f;
    localparam logic [6:0] CMM_LAST_8M = 7'h7f;
    // Connection word fields
    localparam int CMM_MODE_BIT = 0;
    localparam int CMM_SRC_STR_MSB = 11;
    localparam int CMM_SRC_STR_LSB = 8;
    localparam int CMM_SRC_CH_MSB = 7;
    localparam int CMM_SRC_CH_LSB = 1;
    localparam int CMM_MSG_MSB = 10;
    localparam int CMM_MSG_LSB = 3;
    localparam int CMM_OCTL_MSB = 2;
    localparam int CMM_OCTL_LSB = 1;
    localparam logic [1:0] CMM_OCTL_TRI = 2'h0;
    localparam logic [1:0] CMM_OCTL_MSG = 2'h1;
    localparam logic [1:0] CMM_OCTL_BER = 2'h2;
    localparam logic [1:0] CMM_RESP_OK = 2'h0;
    localparam logic [1:0] CMM_RESP_SLVERR = 2'h2;

    typedef enum logic [2:0] {CMM_OUT_SWITCH, CMM_OUT_TRI, CMM_OUT_MSG, CMM_OUT_BER,
        CMM_OUT_RSVD} cmm_out_type;

    typedef struct packed {
        cmm_out_type action;
        logic [3:0] src_stream;
        logic [6:0] src_channel;
        logic [7:0] message;
    } cmm_ctl_type;
endpackage

// *** core/cmm_map.sv ***
// The address map and the AXI4-Lite register port were left to the implementer.
`timescale 1ns/1ps
module cmm_map
    import cmm_pkg::*;
#(
    parameter int STREAMS = 16,
    parameter int CHANNELS = 128
)
(
    input wire logic core_clk, // 40 MHz clock
    input wire logic arst_n, // Async reset
    input wire logic [CMM_AXI_AW-1:0] s_axi_awaddr, // Write address
    input wire logic s_axi_awvalid, // Write address valid
    output logic s_axi_awready, // Write address ready
    input wire logic [31:0] s_axi_wdata, // Write data
    input wire logic [3:0] s_axi_wstrb, // Write strobes
    input wire logic s_axi_wvalid, // Write data valid
    output logic s_axi_wready, // Write data ready
    output logic [1:0] s_axi_bresp, // Write response
    output logic s_axi_bvalid, // Write response valid
    input wire logic s_axi_bready, // Write response ready
    input wire logic [CMM_AXI_AW-1:0] s_axi_araddr, // Read address
    input wire logic s_axi_arvalid, // Read address valid
    output logic s_axi_arready, // Read address ready
    output logic [31:0] s_axi_rdata, // Read data
    output logic [1:0] s_axi_rresp, // Read response
    output logic s_axi_rvalid, // Read data valid
    input wire logic s_axi_rready, // Read data ready
    input wire logic [3:0] look_stream, // Output stream looked up
    input wire logic [6:0] look_channel, // Output channel looked up
    output cmm_ctl_type look_ctl // Decoded connection word, one cycle later
);
    localparam int IDXW = $clog2(STREAMS * CHANNELS);

    logic [CMM_WORD_W-1:0] conn_mem [STREAMS*CHANNELS];
    logic [CMM_WORD_W-1:0] data_mem [STREAMS*CHANNELS];

    function automatic logic [IDXW-1:0] mem_index(input logic [CMM_AXI_AW-1:0] a);
        mem_index = IDXW'({a[CMM_STREAM_MSB:CMM_STREAM_LSB], a[CMM_CHAN_MSB:CMM_CHAN_LSB]});
    endfunction

    function automatic logic chan_used(input logic [1:0] rate, input logic [6:0] ch);
        case (rate)
            CMM_RATE_2M: chan_used = (ch <= CMM_LAST_2M);
            CMM_RATE_4M: chan_used = (ch <= CMM_LAST_4M);
            CMM_RATE_8M: chan_used = (ch <= CMM_LAST_8M);
            default: chan_used = 1'b0;
        endcase
    endfunction

    function automatic cmm_ctl_type decode_word(input logic [CMM_WORD_W-1:0] w);
        decode_word.src_stream = 4'h0;
        decode_word.src_channel = 7'h00;
        decode_word.message = 8'h00;
        if (!w[CMM_MODE_BIT])
        begin
            decode_word.action = CMM_OUT_SWITCH;
            decode_word.src_stream = w[CMM_SRC_STR_MSB:CMM_SRC_STR_LSB];
            decode_word.src_channel = w[CMM_SRC_CH_MSB:CMM_SRC_CH_LSB];
        end
        else
        begin
            case (w[CMM_OCTL_MSB:CMM_OCTL_LSB])
                CMM_OCTL_TRI: decode_word.action = CMM_OUT_TRI;
                CMM_OCTL_MSG: decode_word.action = CMM_OUT_MSG;
                CMM_OCTL_BER: decode_word.action = CMM_OUT_BER;
                default: decode_word.action = CMM_OUT_RSVD;
            endcase
            decode_word.message = w[CMM_MSG_MSB:CMM_MSG_LSB];
        end
    endfunction

    // Bus state
    logic aw_held, next_aw_held, w_held, next_w_held;
    logic [CMM_AXI_AW-1:0] aw_addr, next_aw_addr;
    logic [31:0] w_data, next_w_data;
    logic [3:0] w_strb, next_w_strb;
    logic bvalid, next_bvalid, rvalid, next_rvalid;
    logic aw_ready, next_aw_ready, w_ready, next_w_ready;
    logic ar_ready, next_ar_ready;
    logic [1:0] bresp, next_bresp, rresp, next_rresp;
    logic [31:0] rdata, next_rdata;
    logic [31:0] ctrl, next_ctrl;
    logic [31:0] rate, next_rate;
    logic [31:0] wr_count, next_wr_count;
    logic do_write, mem_we_conn, mem_we_data, wr_mem_ok;
    logic [IDXW-1:0] wr_idx;
    logic [CMM_WORD_W-1:0] wr_word;
    cmm_ctl_type next_look;

    // Readies come from flops so the host never sees a decode glitch
    assign s_axi_awready = aw_ready;
    assign s_axi_wready = w_ready;
    assign s_axi_arready = ar_ready;

    always_comb
    begin
        logic [CMM_AXI_AW-1:0] a;
        logic [31:0] d;
        logic [3:0] s;
        a = aw_held ? aw_addr : s_axi_awaddr;
        d = w_held ? w_data : s_axi_wdata;
        s = w_held ? w_strb : s_axi_wstrb;
        next_aw_held = aw_held;
        next_w_held = w_held;
        next_aw_addr = aw_addr;
        next_w_data = w_data;
        next_w_strb = w_strb;
        next_bvalid = bvalid;
        next_bresp = bresp;
        next_ctrl = ctrl;
        next_rate = rate;
        next_wr_count = wr_count;
        do_write = 1'b0;
        mem_we_conn = 1'b0;
        mem_we_data = 1'b0;
        wr_idx = mem_index(a);
        wr_word = d[CMM_WORD_W-1:0];
        wr_mem_ok = 1'b0;
        if (s_axi_awvalid && s_axi_awready)
        begin
            next_aw_held = 1'b1;
            next_aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready)
        begin
            next_w_held = 1'b1;
            next_w_data = s_axi_wdata;
            next_w_strb = s_axi_wstrb;
        end
        if (s_axi_bvalid && s_axi_bready)
            next_bvalid = 1'b0;
        // Address and data may arrive in either order
        if ((aw_held || (s_axi_awvalid && s_axi_awready))
            && (w_held || (s_axi_wvalid && s_axi_wready)) && !bvalid)
        begin
            do_write = 1'b1;
            next_aw_held = 1'b0;
            next_w_held = 1'b0;
            next_bvalid = 1'b1;
            next_bresp = CMM_RESP_OK;
            if (a[CMM_SPACE_BIT])
            begin
                // Both byte lanes holding the 12-bit word are needed
                wr_mem_ok = s[0] && s[1];
                mem_we_conn = wr_mem_ok && (ctrl[CMM_SEL_W-1:0] == CMM_SEL_CONN);
                mem_we_data = wr_mem_ok && (ctrl[CMM_SEL_W-1:0] == CMM_SEL_DATA);
                if (!(mem_we_conn || mem_we_data))
                    next_bresp = CMM_RESP_SLVERR;
                else
                    next_wr_count = wr_count + 32'h00000001;
            end
            else
            begin
                case (a[CMM_SPACE_BIT-1:0])
                    CMM_OFS_CTRL:
                        for (int i = 0; i < 4; i++)
                            if (s[i])
                                next_ctrl[i*8 +: 8] = d[i*8 +: 8];
                    CMM_OFS_RATE:
                        for (int i = 0; i < 4; i++)
                            if (s[i])
                                next_rate[i*8 +: 8] = d[i*8 +: 8];
                    CMM_OFS_STAT: next_bresp = CMM_RESP_SLVERR;
                    default: next_bresp = CMM_RESP_SLVERR;
                endcase
            end
        end
        // Ready again only once the response has been taken
        next_aw_ready = !next_aw_held && !next_bvalid;
        next_w_ready = !next_w_held && !next_bvalid;
    end

    always_comb
    begin
        next_rvalid = rvalid;
        next_rdata = rdata;
        next_rresp = rresp;
        if (s_axi_rvalid && s_axi_rready)
            next_rvalid = 1'b0;
        if (s_axi_arvalid && s_axi_arready)
        begin
            next_rvalid = 1'b1;
            next_rresp = CMM_RESP_OK;
            next_rdata = 32'h00000000;
            if (s_axi_araddr[CMM_SPACE_BIT])
            begin
                case (ctrl[CMM_SEL_W-1:0])
                    CMM_SEL_CONN:
                        next_rdata[CMM_WORD_W-1:0] = conn_mem[mem_index(s_axi_araddr)];
                    CMM_SEL_DATA:
                        next_rdata[CMM_WORD_W-1:0] = data_mem[mem_index(s_axi_araddr)];
                    default: next_rresp = CMM_RESP_SLVERR;
                endcase
            end
            else
            begin
                case (s_axi_araddr[CMM_SPACE_BIT-1:0])
                    CMM_OFS_CTRL: next_rdata = ctrl;
                    CMM_OFS_RATE: next_rdata = rate;
                    CMM_OFS_STAT: next_rdata = wr_count;
                    default: next_rresp = CMM_RESP_SLVERR;
                endcase
            end
        end
        next_ar_ready = !next_rvalid;
    end

    always_comb
    begin
        logic [1:0] r;
        r = rate[look_stream*2 +: 2];
        next_look = decode_word(conn_mem[mem_index({1'b1, look_stream, look_channel})]);
        // unused positions stay quiet, whatever the stored word says
        if (!chan_used(r, look_channel))
            next_look.action = CMM_OUT_TRI;
    end

    always_ff @(posedge core_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            aw_addr <= '0;
            w_data <= 32'h00000000;
            w_strb <= 4'h0;
            bvalid <= 1'b0;
            bresp <= CMM_RESP_OK;
            rvalid <= 1'b0;
            aw_ready <= 1'b1;
            w_ready <= 1'b1;
            ar_ready <= 1'b1;
            rresp <= CMM_RESP_OK;
            rdata <= 32'h00000000;
            ctrl <= 32'h00000000;
            rate <= CMM_RATE_RST;
            wr_count <= 32'h00000000;
            look_ctl <= '{CMM_OUT_TRI, 4'h0, 7'h00, 8'h00};
        end
        else
        begin
            aw_held <= next_aw_held;
            w_held <= next_w_held;
            aw_addr <= next_aw_addr;
            w_data <= next_w_data;
            w_strb <= next_w_strb;
            bvalid <= next_bvalid;
            bresp <= next_bresp;
            rvalid <= next_rvalid;
            aw_ready <= next_aw_ready;
            w_ready <= next_w_ready;
            ar_ready <= next_ar_ready;
            rresp <= next_rresp;
            rdata <= next_rdata;
            ctrl <= next_ctrl;
            rate <= next_rate;
            wr_count <= next_wr_count;
            look_ctl <= next_look;
        end
    end

    // Memories carry no reset; contents are undefined until written
    always_ff @(posedge core_clk)
    begin
        if (mem_we_conn)
            conn_mem[wr_idx] <= wr_word;
        if (mem_we_data)
            data_mem[wr_idx] <= wr_word;
    end

    assign s_axi_bvalid = bvalid;
    assign s_axi_bresp = bresp;
    assign s_axi_rvalid = rvalid;
    assign s_axi_rresp = rresp;
    assign s_axi_rdata = rdata;
endmodule

// *** sim/cmm_map_assertions.sv ***
`timescale 1ns/1ps
module cmm_map_chk
    import cmm_pkg::*;
(
    input wire logic core_clk, // In
    input wire logic arst_n, // In
    input wire logic [CMM_AXI_AW-1:0] s_axi_awaddr, // In
    input wire logic s_axi_awvalid, // In
    input wire logic s_axi_awready, // In
    input wire logic s_axi_wvalid, // In
    input wire logic s_axi_wready, // In
    input wire logic [1:0] s_axi_bresp, // In
    input wire logic s_axi_bvalid, // In
    input wire logic s_axi_bready, // In
    input wire logic [CMM_AXI_AW-1:0] s_axi_araddr, // In
    input wire logic s_axi_arvalid, // In
    input wire logic s_axi_arready, // In
    input wire logic [31:0] s_axi_rdata, // In
    input wire logic s_axi_rvalid, // In
    input wire logic s_axi_rready, // In
    input cmm_ctl_type look_ctl // In
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!arst_n);
    logic wtake;
    assign wtake = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    bresp_once_a: assert property (s_axi_bvalid && s_axi_bready
        |=> !s_axi_bvalid) else $error("write answer repeated");
    rdata_once_a: assert property (s_axi_rvalid && s_axi_rready
        |=> !s_axi_rvalid) else $error("read answer repeated");
    write_resp_a: assert property (wtake |=> s_axi_bvalid) else $error("no write answer");
    read_resp_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("no read answer");
    read_busy_a: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read taken while busy");
    write_busy_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write taken while busy");
    stat_ro_a: assert property (wtake && !s_axi_awaddr[11]
        && s_axi_awaddr[10:0] == CMM_OFS_STAT |=> s_axi_bresp == CMM_RESP_SLVERR)
        else $error("status write accepted");
    mem_width_a: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr[11]
        |=> s_axi_rdata[31:12] == 20'h00000) else $error("memory word too wide");
    switch_msg_a: assert property (look_ctl.action == CMM_OUT_SWITCH
        |-> look_ctl.message == 8'h00) else $error("switch carries a message");
    cover property (s_axi_bvalid && s_axi_bresp == CMM_RESP_SLVERR);
    cover property (s_axi_rvalid && s_axi_rready);
    cover property (look_ctl.action == CMM_OUT_MSG);
endmodule
bind cmm_map cmm_map_chk u_chk (.*);

// *** sim/cmm_host.sv ***
`timescale 1ns/1ps
module cmm_host;
    // Tasks drive tb_top signals; callers start right after a clock edge
    task automatic wr(input logic [11:0] a, input logic [31:0] d, output logic [1:0] r);
        logic ta;
        logic tw;
        ta = 1'b0;
        tw = 1'b0;
        tb_top.s_axi_awaddr <= a;
        tb_top.s_axi_wdata <= d;
        {tb_top.s_axi_awvalid, tb_top.s_axi_wvalid, tb_top.s_axi_bready} <= 3'h7;
        do
        begin
            @(posedge tb_top.core_clk);
            ta = ta | tb_top.s_axi_awready;
            tw = tw | tb_top.s_axi_wready;
            tb_top.s_axi_awvalid <= !ta;
            tb_top.s_axi_wvalid <= !tw;
        end while (!(ta && tw));
        // Released lines show garbage, not the last value
        tb_top.s_axi_awaddr <= ~a;
        tb_top.s_axi_wdata <= ~d;
        do @(posedge tb_top.core_clk); while (tb_top.s_axi_bvalid !== 1'b1);
        r = tb_top.s_axi_bresp;
        tb_top.s_axi_bready <= 1'b0;
        // One edge between calls, so no line is driven twice in a step
        @(posedge tb_top.core_clk);
    endtask
    task automatic rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
        tb_top.s_axi_araddr <= a;
        {tb_top.s_axi_arvalid, tb_top.s_axi_rready} <= 2'h3;
        do @(posedge tb_top.core_clk); while (tb_top.s_axi_arready !== 1'b1);
        tb_top.s_axi_arvalid <= 1'b0;
        tb_top.s_axi_araddr <= ~a;
        do @(posedge tb_top.core_clk); while (tb_top.s_axi_rvalid !== 1'b1);
        d = tb_top.s_axi_rdata;
        r = tb_top.s_axi_rresp;
        tb_top.s_axi_rready <= 1'b0;
        @(posedge tb_top.core_clk);
    endtask
endmodule

// *** sim/tb_top.sv ***
`timescale 1ns/1ps
module tb_top;
    import cmm_pkg::*;
    logic core_clk = 1'b0;
    logic arst_n = 1'b0;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [11:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000, a;
    logic [31:0] s_axi_wdata = 32'h00000000, s_axi_rdata, d, w;
    logic [3:0] s_axi_wstrb = 4'hf, look_stream = 4'h0;
    logic [1:0] s_axi_bresp, s_axi_rresp, r;
    logic [6:0] look_channel = 7'h00;
    cmm_ctl_type look_ctl, e;
    int num_errors = 0, checks_done = 0, wcount = 0;
    always #12.5 core_clk = ~core_clk;
    cmm_map u_dut (.*);
    cmm_host u_host ();
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp)
        begin
            num_errors++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic end_of_test;
        $display("checks %0d mismatches %0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    // Expected lookup of word w on a channel of a stream at rate code rt
    function automatic cmm_ctl_type dec(logic [11:0] w, logic [1:0] rt, logic [6:0] ch);
        cmm_ctl_type x;
        x = '0;
        x.action = CMM_OUT_TRI;
        if (rt == 2'h3 || int'(ch) > (32 << rt) - 1)
            return x;
        x.src_stream = w[11:8];
        x.src_channel = w[7:1];
        x.message = w[10:3];
        if (!w[0])
            x.action = CMM_OUT_SWITCH;
        else
            x.action = cmm_out_type'(3'(w[2:1]) + 3'h1);
        return x;
    endfunction
    initial
    begin
        repeat (20000) @(posedge core_clk);
        num_errors++;
        end_of_test();
    end
    initial
    begin
        void'($urandom(32'h15d0d396));
        repeat (8) @(posedge core_clk);
        chk(look_ctl.action, CMM_OUT_TRI);
        arst_n <= 1'b1;
        u_host.rd(12'h004, d, r);
        chk(d, CMM_RATE_RST);
        u_host.wr(12'h004, 32'he4e4e4e4, r);
        u_host.rd(12'h004, d, r);
        chk(d, 32'he4e4e4e4);
        u_host.wr(12'h008, 32'h1, r);
        chk(r, CMM_RESP_SLVERR);
        u_host.rd(12'h00c, d, r);
        chk(r, CMM_RESP_SLVERR);
        $display("register test done");
        for (int i = 0; i < 48; i++)
        begin
            a = {1'b1, 11'($urandom)};
            w = $urandom;
            w[2:0] = 3'(i % 7);
            u_host.wr(a, w, r);
            chk(r, CMM_RESP_OK);
            wcount++;
            u_host.rd(a, d, r);
            chk(d, {20'h00000, w[11:0]});
            look_stream <= a[10:7];
            look_channel <= a[6:0];
            repeat (2) @(posedge core_clk);
            e = dec(w[11:0], 2'(a[10:7]), a[6:0]);
            chk(look_ctl.action, e.action);
            if (e.action == CMM_OUT_SWITCH)
                chk({look_ctl.src_stream, look_ctl.src_channel}, {e.src_stream, e.src_channel});
            if (e.action == CMM_OUT_MSG)
                chk(look_ctl.message, e.message);
        end
        $display("connection test done");
        u_host.wr(12'h000, 32'h1, r);
        u_host.wr(a, 32'habc, r);
        wcount++;
        u_host.rd(a, d, r);
        chk(d, 32'habc);
        u_host.wr(12'h000, 32'h0, r);
        u_host.rd(a, d, r);
        chk(d, {20'h00000, w[11:0]});
        u_host.wr(12'h000, 32'h2, r);
        u_host.wr(a, 32'h5, r);
        chk(r, CMM_RESP_SLVERR);
        u_host.wr(12'h000, 32'h0, r);
        u_host.rd(12'h008, d, r);
        chk(d, 32'(wcount));
        $display("select test done");
        arst_n <= 1'b0;
        repeat (2) @(posedge core_clk);
        chk(look_ctl.action, CMM_OUT_TRI);
        chk({s_axi_awready, s_axi_wready, s_axi_arready, s_axi_bvalid, s_axi_rvalid}, 5'h1c);
        arst_n <= 1'b1;
        u_host.rd(12'h004, d, r);
        chk(d, CMM_RATE_RST);
        u_host.rd(12'h008, d, r);
        chk(d, 32'h00000000);
        $display("reset test done");
        end_of_test();
    end
endmodule
